/* verilog/wdwrf_pkg.sv */
// Purpose: Shared constants and types for the watchdog and reset flag block
// Assumes: Registers sit in byte lane 0 of a 32-bit classic Wishbone slave
// Notes: Offsets are byte addresses, one aligned word per register
package wdwrf_pkg;

	// Register byte addresses
	localparam logic [7:0] WDWRF_ADDR_STATUS = 8'h00;
	localparam logic [7:0] WDWRF_ADDR_CONTROL = 8'h04;
	localparam logic [7:0] WDWRF_ADDR_RESTART = 8'h08;

	// Status register field positions
	localparam int WDWRF_FLAG_POWER = 0;
	localparam int WDWRF_FLAG_PIN = 1;
	localparam int WDWRF_FLAG_DROOP = 2;
	localparam int WDWRF_FLAG_TIMEOUT = 3;
	localparam int WDWRF_FLAG_SCAN = 4;
	localparam int WDWRF_FLAG_COUNT = 5;

	// Control register field positions
	localparam int WDWRF_CTRL_PERIOD_LSB = 0;
	localparam int WDWRF_CTRL_PERIOD_MSB = 2;
	localparam int WDWRF_CTRL_ENABLE = 3;
	localparam int WDWRF_CTRL_CHANGE = 4;

	// Restart register field position
	localparam int WDWRF_RESTART_BIT = 0;

	// Reset values
	localparam logic [4:0] WDWRF_STATUS_RESET = 5'h01;
	localparam logic [2:0] WDWRF_PERIOD_RESET = 3'h0;

	// Change-enable window length in system clock cycles
	localparam logic [2:0] WDWRF_CE_WINDOW_CYCLES = 3'h4;

	// Watchdog oscillator rate and shortest period (16K cycles as a power of two)
	localparam int WDWRF_OSC_FREQ_HZ = 1000000;
	localparam int WDWRF_BASE_PERIOD_LOG2 = 14;
	localparam int WDWRF_PERIOD_STEPS = 7;

	// Chip reset sources other than power-on, held as levels
	typedef struct packed {
		logic scan;
		logic droop;
		logic pin;
	} wdwrf_rst_src_t;

	// Watchdog control fields
	typedef struct packed {
		logic change_enable;
		logic timer_enable;
		logic [2:0] period_select;
	} wdwrf_ctrl_t;

endpackage

/* verilog/wdwrf_top.sv */
// Purpose: Watchdog timer with reset-source flags behind a Wishbone slave
// Assumes: resetn_in is the power-on reset; other sources arrive as levels
// Notes: Oscillator input is a plain synchronous input, edge detected
// Operation
// - Scan-chain reset sets its flag; zero write clears
// - Watchdog timeout sets its flag; zero write clears
// - Brown-out reset sets droop flag; zero write clears
// - Pin reset sets pin flag; zero write clears
// - Power-on sets power flag; only zero write clears
// - Counter advances on separate 1 MHz oscillator
// - Restart command returns count to zero
// - Disable or chip reset also clears count
// - Expired period while enabled resets the chip
// - Fuse picks level one or level two
// - Level two ignores every disable attempt
// - Control bits seven to five read zero
// - Change enable self-clears four cycles later
// - Enable one enables; zero needs change enable
// - Disable: write both ones, then zero soon
// - Period change only while change enable set
// - Period codes give 16K doubling to 2048K
// - Timeout gives one-cycle internal reset pulse
// - Level one enables with a single write
// - Level two enable bit always reads one
// - Level two ignores enable in second write
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module wdwrf_top
	import wdwrf_pkg::*;
#(
	parameter int BASE_PERIOD_LOG2 = WDWRF_BASE_PERIOD_LOG2
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic wdt_osc_in,
	input wire logic always_on_fuse_in,
	input wire wdwrf_rst_src_t rst_src_in,
	output logic chip_reset_out,
	output logic wdt_active_out
);

	localparam int CNT_W = BASE_PERIOD_LOG2 + WDWRF_PERIOD_STEPS;

	logic bus_ack;
	logic [31:0] bus_dat;
	logic [WDWRF_FLAG_COUNT-1:0] flags;
	wdwrf_ctrl_t ctrl;
	logic ctrl_en;
	logic [2:0] ctrl_period;
	logic [2:0] ce_cnt;
	logic osc_q;
	logic cnt_clear_q;
	logic enabled_q;
	logic [2:0] period_q;
	logic [CNT_W-1:0] cnt;
	logic timeout_pulse;

	// Bus decode; registers live in byte lane 0 only
	wire req = wb_cyc_in & wb_stb_in & ~bus_ack;
	wire wr = req & wb_we_in & wb_sel_in[0];
	wire sel_status = (wb_adr_in == WDWRF_ADDR_STATUS);
	wire sel_ctrl = (wb_adr_in == WDWRF_ADDR_CONTROL);
	wire sel_restart = (wb_adr_in == WDWRF_ADDR_RESTART);
	wire [7:0] wdat = wb_dat_in[7:0];
	wire wr_status = wr & sel_status;
	wire wr_ctrl = wr & sel_ctrl;
	wire restart_wr = wr & sel_restart & wdat[WDWRF_RESTART_BIT];

	// Fuse level and chip reset; fuse is a level, not a caught strap
	wire level2 = always_on_fuse_in;
	wire chip_rst = rst_src_in.scan | rst_src_in.droop | rst_src_in.pin | timeout_pulse;
	wire ce_open = (ce_cnt != 3'h0);
	wire enabled = ctrl.timer_enable | level2;
	wire open_req = wr_ctrl & wdat[WDWRF_CTRL_CHANGE] & wdat[WDWRF_CTRL_ENABLE];

	// Enable bit: a one enables unless chip reset, a zero needs the open window
	wire en_write = wdat[WDWRF_CTRL_ENABLE];
	wire next_en = chip_rst ? 1'b0 :
		(wr_ctrl & en_write) ? 1'b1 :
		(wr_ctrl & ~en_write & ce_open) ? 1'b0 :
		ctrl.timer_enable;

	// Period only moves inside the window
	wire period_wr = wr_ctrl & ce_open;
	wire [2:0] next_period = chip_rst ? WDWRF_PERIOD_RESET :
		period_wr ? wdat[WDWRF_CTRL_PERIOD_MSB:WDWRF_CTRL_PERIOD_LSB] :
		ctrl.period_select;

	// Window counter: loaded on the opening write, runs down to zero
	wire [2:0] next_ce_cnt = chip_rst ? 3'h0 :
		open_req ? WDWRF_CE_WINDOW_CYCLES :
		ce_open ? ce_cnt - 3'h1 :
		3'h0;

	// Control register
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_en <= 1'b0;
			ctrl_period <= WDWRF_PERIOD_RESET;
			ce_cnt <= 3'h0;
		end else begin
			ctrl_en <= next_en;
			ctrl_period <= next_period;
			ce_cnt <= next_ce_cnt;
		end
	end

	// Whole struct from one driver; change-enable is the window state itself
	assign ctrl = {ce_open, ctrl_en, ctrl_period};

	// Staging register between control side and counter
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_clear_q <= 1'b1;
			enabled_q <= 1'b0;
			period_q <= WDWRF_PERIOD_RESET;
		end else begin
			cnt_clear_q <= restart_wr | ~enabled | chip_rst;
			enabled_q <= enabled;
			period_q <= ctrl.period_select;
		end
	end

	// Oscillator edge; the oscillator is taken as synchronous to the system clock
	wire osc_tick = wdt_osc_in & ~osc_q;

	// Terminal count: all ones shifted down by the unused period steps
	wire [2:0] shift_amt = 3'(WDWRF_PERIOD_STEPS) - period_q;
	wire [CNT_W-1:0] term_cnt = {CNT_W{1'b1}} >> shift_amt;
	wire at_limit = (cnt == term_cnt);
	wire expire = osc_tick & enabled_q & ~cnt_clear_q & at_limit;

	// Watchdog counter
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			osc_q <= 1'b0;
			cnt <= '0;
		end else begin
			osc_q <= wdt_osc_in;
			if (cnt_clear_q || expire) begin
				cnt <= '0;
			end else if (osc_tick && enabled_q) begin
				cnt <= cnt + CNT_W'(1);
			end
		end
	end

	// Timeout pulse lasts one cycle; chip reset then clears the counter
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			timeout_pulse <= 1'b0;
		end else begin
			timeout_pulse <= expire & ~timeout_pulse;
		end
	end

	assign chip_reset_out = timeout_pulse;
	assign wdt_active_out = enabled_q;

	// Flag set and clear terms; set beats a same-cycle clear
	wire [WDWRF_FLAG_COUNT-1:0] flag_set;
	wire [WDWRF_FLAG_COUNT-1:0] flag_clr;
	assign flag_set[WDWRF_FLAG_POWER] = 1'b0;
	assign flag_set[WDWRF_FLAG_PIN] = rst_src_in.pin;
	assign flag_set[WDWRF_FLAG_DROOP] = rst_src_in.droop;
	assign flag_set[WDWRF_FLAG_TIMEOUT] = timeout_pulse;
	assign flag_set[WDWRF_FLAG_SCAN] = rst_src_in.scan;
	assign flag_clr = wr_status ? ~wdat[WDWRF_FLAG_COUNT-1:0] : '0;

	// One flop per flag; power-on reset loads the power flag only
	genvar gi;
	generate
		for (gi = 0; gi < WDWRF_FLAG_COUNT; gi++) begin : g_flag
			always_ff @(posedge clk_sys_in or negedge resetn_in) begin
				if (!resetn_in) begin
					flags[gi] <= WDWRF_STATUS_RESET[gi];
				end else begin
					flags[gi] <= (flags[gi] & ~flag_clr[gi]) | flag_set[gi];
				end
			end
		end
	endgenerate

	// Read selection; unmapped addresses answer with zero
	wire [7:0] ctrl_rd = {3'h0, ctrl.change_enable, enabled, ctrl.period_select};
	wire [7:0] status_rd = {3'h0, flags};
	wire [7:0] rd_byte = sel_status ? status_rd :
		sel_ctrl ? ctrl_rd :
		8'h00;

	// Bus answer one cycle after the strobe, dropped the cycle after
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bus_ack <= 1'b0;
			bus_dat <= 32'h0000_0000;
		end else begin
			bus_ack <= req;
			if (req) begin
				bus_dat <= {24'h00_0000, rd_byte};
			end
		end
	end

	assign wb_ack_out = bus_ack;
	assign wb_dat_out = bus_dat;

	// Checks on the design's own outputs and state
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	property p_ce_holds;
		(open_req && !chip_rst) ##1 (!chip_rst)[*3] |-> ce_open;
	endproperty
	a_ce_holds: assert property (p_ce_holds) else $error("window closed early");

	property p_ce_closes;
		(open_req && !chip_rst) ##1 (!open_req)[*4] |=> !ce_open;
	endproperty
	a_ce_closes: assert property (p_ce_closes) else $error("window stayed open");

	property p_en_locked;
		(wr_ctrl && !en_write && !ce_open && ctrl.timer_enable && !chip_rst)
			|=> ctrl.timer_enable;
	endproperty
	a_en_locked: assert property (p_en_locked) else $error("disabled without window");

	property p_level2_on;
		level2 && !chip_rst |=> enabled_q;
	endproperty
	a_level2_on: assert property (p_level2_on) else $error("level two watchdog off");

	property p_level2_reads_one;
		(req && sel_ctrl && !wb_we_in && level2) |=> wb_dat_out[WDWRF_CTRL_ENABLE];
	endproperty
	a_level2_reads_one: assert property (p_level2_reads_one) else $error("enable read zero");

	property p_upper_zero;
		wb_ack_out |-> (wb_dat_out[31:5] == 27'h0);
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("reserved bits nonzero");

	property p_pulse_one;
		chip_reset_out |=> !chip_reset_out;
	endproperty
	a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");

	property p_timeout_flag;
		chip_reset_out |=> flags[WDWRF_FLAG_TIMEOUT];
	endproperty
	a_timeout_flag: assert property (p_timeout_flag) else $error("timeout flag missed");

	property p_droop_flag;
		rst_src_in.droop |=> flags[WDWRF_FLAG_DROOP];
	endproperty
	a_droop_flag: assert property (p_droop_flag) else $error("droop flag missed");

	property p_power_sticky;
		flags[WDWRF_FLAG_POWER] && !(wr_status && !wdat[WDWRF_FLAG_POWER])
			|=> flags[WDWRF_FLAG_POWER];
	endproperty
	a_power_sticky: assert property (p_power_sticky) else $error("power flag lost");

	property p_power_never_sets;
		!flags[WDWRF_FLAG_POWER] |=> !flags[WDWRF_FLAG_POWER];
	endproperty
	a_power_never_sets: assert property (p_power_never_sets) else $error("power flag set");

	property p_one_write_keeps;
		(flags[WDWRF_FLAG_PIN] && wr_status && wdat[WDWRF_FLAG_PIN]) |=> flags[WDWRF_FLAG_PIN];
	endproperty
	a_one_write_keeps: assert property (p_one_write_keeps) else $error("flag cleared by one");

	property p_restart_clears;
		restart_wr |=> ##1 (cnt == '0);
	endproperty
	a_restart_clears: assert property (p_restart_clears) else $error("restart ignored");

	property p_disable_clears;
		!enabled |=> ##1 (cnt == '0);
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("count kept while off");

	property p_period_locked;
		(wr_ctrl && !ce_open && !chip_rst) |=> $stable(ctrl.period_select);
	endproperty
	a_period_locked: assert property (p_period_locked) else $error("period changed closed");

	property p_expire_resets;
		expire && !timeout_pulse |=> chip_reset_out ##1 flags[WDWRF_FLAG_TIMEOUT];
	endproperty
	a_expire_resets: assert property (p_expire_resets) else $error("no reset on expiry");

	property p_scan_flag;
		rst_src_in.scan |=> flags[WDWRF_FLAG_SCAN];
	endproperty
	a_scan_flag: assert property (p_scan_flag) else $error("scan flag missed");

	property p_scan_clear;
		wr_status && !wdat[WDWRF_FLAG_SCAN] && !rst_src_in.scan |=> !flags[WDWRF_FLAG_SCAN];
	endproperty
	a_scan_clear: assert property (p_scan_clear) else $error("scan flag kept");

	property p_pin_flag;
		rst_src_in.pin |=> flags[WDWRF_FLAG_PIN];
	endproperty
	a_pin_flag: assert property (p_pin_flag) else $error("pin flag missed");

	property p_pin_clear;
		wr_status && !wdat[WDWRF_FLAG_PIN] && !rst_src_in.pin |=> !flags[WDWRF_FLAG_PIN];
	endproperty
	a_pin_clear: assert property (p_pin_clear) else $error("pin flag kept");

	property p_droop_clear;
		wr_status && !wdat[WDWRF_FLAG_DROOP] && !rst_src_in.droop |=> !flags[WDWRF_FLAG_DROOP];
	endproperty
	a_droop_clear: assert property (p_droop_clear) else $error("droop flag kept");

	property p_timeout_clear;
		wr_status && !wdat[WDWRF_FLAG_TIMEOUT] && !timeout_pulse |=> !flags[WDWRF_FLAG_TIMEOUT];
	endproperty
	a_timeout_clear: assert property (p_timeout_clear) else $error("timeout flag kept");

	property p_reset_disables;
		chip_rst |=> !ctrl.timer_enable;
	endproperty
	a_reset_disables: assert property (p_reset_disables) else $error("enable kept on reset");

	property p_reset_period;
		chip_rst |=> (ctrl.period_select == WDWRF_PERIOD_RESET);
	endproperty
	a_reset_period: assert property (p_reset_period) else $error("period kept on reset");

	property p_enable_write;
		wr_ctrl && en_write && !chip_rst |=> ctrl.timer_enable;
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost");

	property p_disable_window;
		wr_ctrl && !en_write && ce_open && !chip_rst |=> !ctrl.timer_enable;
	endproperty
	a_disable_window: assert property (p_disable_window) else $error("disable ignored");

	property p_level2_ignores;
		level2 && wr_ctrl && !en_write && ce_open |=> enabled_q;
	endproperty
	a_level2_ignores: assert property (p_level2_ignores) else $error("level two disabled");

	property p_period_write;
		wr_ctrl && ce_open && !chip_rst
			|=> (ctrl.period_select == $past(wdat[WDWRF_CTRL_PERIOD_MSB:WDWRF_CTRL_PERIOD_LSB]));
	endproperty
	a_period_write: assert property (p_period_write) else $error("period write lost");

	property p_count_steps;
		osc_tick && enabled_q && !cnt_clear_q && !at_limit |=> (cnt == $past(cnt) + CNT_W'(1));
	endproperty
	a_count_steps: assert property (p_count_steps) else $error("count did not step");

	property p_count_holds;
		!osc_tick && !cnt_clear_q |=> $stable(cnt);
	endproperty
	a_count_holds: assert property (p_count_holds) else $error("count moved idle");

	// Main scenarios
	c_timeout: cover property (chip_reset_out);
	c_level2_hold: cover property (level2 && wr_ctrl && !en_write && ce_open);
	c_disable: cover property (ctrl.timer_enable ##1 open_req ##[1:4] !ctrl.timer_enable);
	c_period: cover property (period_wr ##1 $changed(ctrl.period_select));
	c_restart: cover property (restart_wr && enabled);

endmodule

/* dv/wdwrf_top_tb.sv */
// Purpose: Self-checking bench for the watchdog and reset flag block
// Assumes: Short periods via BASE_PERIOD_LOG2 = 2; oscillator edge every 100 cycles
// Notes: Checks are made on values sampled at the edge where ack is seen
`timescale 1ns/1ns
module wdwrf_top_tb;
	import wdwrf_pkg::*;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic osc = 1'b0;
	logic fuse = 1'b0;
	wdwrf_rst_src_t src = '0;
	logic chip_rst;
	logic active;
	int oc = 0;
	int rst_cnt = 0;
	int error_cnt = 0;
	int n_compared = 0;
	logic [7:0] q;

	always #5 clk_sys_in = ~clk_sys_in;

	// Slow oscillator and timeout pulse tally
	always @(posedge clk_sys_in) begin
		oc <= (oc == 49) ? 0 : oc + 1;
		if (oc == 49) begin
			osc <= ~osc;
		end
		if (chip_rst === 1'b1) begin
			rst_cnt <= rst_cnt + 1;
		end
	end

	wdwrf_top #(.BASE_PERIOD_LOG2(2)) u_wdwrf_top (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.wb_cyc_in(cyc),
		.wb_stb_in(stb),
		.wb_we_in(we),
		.wb_adr_in(adr),
		.wb_sel_in(4'h1),
		.wb_dat_in(wdat),
		.wb_dat_out(rdat),
		.wb_ack_out(ack),
		.wdt_osc_in(osc),
		.always_on_fuse_in(fuse),
		.rst_src_in(src),
		.chip_reset_out(chip_rst),
		.wdt_active_out(active)
	);

	task automatic end_sim();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic single cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			end_sim();
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		chk(q, exp);
	endtask

	task automatic rst();
		resetn_in <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
	endtask

	task automatic t_reset_values();
		rdc(WDWRF_ADDR_STATUS, 8'h01);
		rdc(WDWRF_ADDR_CONTROL, 8'h00);
		wb(1'b1, 8'h0c, 8'hff);
		rdc(8'h0c, 8'h00);
		rdc(WDWRF_ADDR_RESTART, 8'h00);
	endtask

	// Each source pulses once; writing ones must not disturb flags
	task automatic t_flags();
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h08);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys_in);
			src <= wdwrf_rst_src_t'(3'b001 << i);
			@(posedge clk_sys_in);
			src <= '0;
		end
		rdc(WDWRF_ADDR_CONTROL, 8'h00);
		rdc(WDWRF_ADDR_STATUS, 8'h17);
		wb(1'b1, WDWRF_ADDR_STATUS, 8'hff);
		rdc(WDWRF_ADDR_STATUS, 8'h17);
		wb(1'b1, WDWRF_ADDR_STATUS, 8'h00);
		rdc(WDWRF_ADDR_STATUS, 8'h00);
	endtask

	// Level one: enable freely, disable and period only inside the window
	task automatic t_level1();
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h08);
		rdc(WDWRF_ADDR_CONTROL, 8'h08);
		chk(active, 1'b1);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h00);
		rdc(WDWRF_ADDR_CONTROL, 8'h08);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'hf8);
		rdc(WDWRF_ADDR_CONTROL, 8'h18);
		repeat (5) @(posedge clk_sys_in);
		rdc(WDWRF_ADDR_CONTROL, 8'h08);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h0b);
		rdc(WDWRF_ADDR_CONTROL, 8'h08);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h18);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h09);
		rdc(WDWRF_ADDR_CONTROL, 8'h09);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h18);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h00);
		rdc(WDWRF_ADDR_CONTROL, 8'h00);
	endtask

	// Restarts every 150 cycles keep a 400-cycle period from expiring
	task automatic t_restart();
		int b;
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h08);
		b = rst_cnt;
		repeat (6) begin
			repeat (150) @(posedge clk_sys_in);
			wb(1'b1, WDWRF_ADDR_RESTART, 8'h01);
		end
		chk(8'(rst_cnt - b), 8'h00);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h18);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h00);
	endtask

	// Period 2^(2+code) oscillator edges, each 100 system cycles
	task automatic t_timeout(input logic [2:0] code, input int lo, input int hi);
		int n;
		n = 0;
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h18);
		wb(1'b1, WDWRF_ADDR_CONTROL, {5'h01, code});
		while (chip_rst !== 1'b1 && n < 3000) begin
			@(posedge clk_sys_in);
			n++;
		end
		if (n >= 3000) begin
			error_cnt++;
			end_sim();
		end
		chk(8'(n >= lo && n <= hi), 8'h01);
		@(posedge clk_sys_in);
		chk(chip_rst, 1'b0);
		rdc(WDWRF_ADDR_STATUS, 8'h08);
		rdc(WDWRF_ADDR_CONTROL, 8'h00);
		chk(active, 1'b0);
		wb(1'b1, WDWRF_ADDR_STATUS, 8'h00);
	endtask

	// Level two: always on, disable ignored, period still changeable
	task automatic t_level2();
		fuse <= 1'b1;
		rst();
		chk(active, 1'b1);
		rdc(WDWRF_ADDR_CONTROL, 8'h08);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h18);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h00);
		rdc(WDWRF_ADDR_CONTROL, 8'h08);
		chk(active, 1'b1);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h18);
		wb(1'b1, WDWRF_ADDR_CONTROL, 8'h01);
		rdc(WDWRF_ADDR_CONTROL, 8'h09);
		fuse <= 1'b0;
	endtask

	initial begin
		rst();
		t_reset_values();
		t_flags();
		t_level1();
		t_restart();
		t_timeout(3'h0, 290, 420);
		t_timeout(3'h1, 690, 830);
		t_level2();
		end_sim();
	end
endmodule
